/* File: verilog/ofc_pkg.sv */
// shared constants, types and helper functions of the fuse controller
package ofc_pkg;
  localparam logic [8:0]  A_PGM0      = 9'h000;
  localparam logic [8:0]  A_CHK0      = 9'h020;
  localparam logic [8:0]  A_RB0       = 9'h02c;
  localparam logic [8:0]  A_RB_LAST   = 9'h178;
  localparam logic [8:0]  A_CONF      = 9'h1a0;
  localparam logic [8:0]  A_CMD       = 9'h1a4;
  localparam logic [8:0]  A_RAW       = 9'h1a8;
  localparam logic [8:0]  A_ENA       = 9'h1ac;
  localparam logic [8:0]  A_CLR       = 9'h1b0;
  localparam logic [8:0]  A_BLK       = 9'h1b4;
  localparam logic [8:0]  A_ERR       = 9'h1b8;
  localparam logic [15:0] KEY_PGM     = 16'h5a5a;
  localparam logic [15:0] KEY_RD      = 16'h5aa5;
  localparam int          CMD_RD_BIT  = 0;
  localparam int          CMD_PGM_BIT = 1;
  localparam int          RB_WORDS    = 84;
  localparam logic [3:0]  LAST_BLK    = 4'ha;
  localparam logic [3:0]  FIRST_KEY   = 4'h4;
  localparam logic [4:0]  B0_LAST     = 5'h14;
  localparam logic [4:0]  BLK_LAST    = 5'h0a;
  localparam logic [4:0]  DATA_SLOTS  = 5'h08;
  localparam logic [4:0]  B1_WORDS    = 5'h06;
  localparam logic [4:0]  WP_BLK1_BIT = 5'h14;
  localparam logic [7:0]  PHYS_B1     = 8'h15;
  localparam logic [7:0]  SLOT_WORDS  = 8'h0b;
  localparam logic [2:0]  KEY_COUNT   = 3'h6;
  localparam int          KP_W        = 4;
  localparam logic [7:0]  RS_POLY     = 8'h1d;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PGM  = 2'b01,
    ST_RD   = 2'b10,
    ST_FIN  = 2'b11
  } ofc_state_t;

  // physical word: block 0 slots 0..20, then eleven slots per coded block
  function automatic logic [7:0] phys_addr(input logic [3:0] blk, input logic [4:0] slot);
    if (blk == 4'h0) return {3'h0, slot};
    return PHYS_B1 + 8'(({4'h0, blk} - 8'h01) * SLOT_WORDS) + {3'h0, slot};
  endfunction

  function automatic logic [2:0] b0_word(input logic [4:0] slot);
    logic [4:0] s;
    s = slot - 5'h01;
    return 3'(s >> 2) + 3'h1;
  endfunction

  function automatic logic [6:0] rb_lin(input logic [3:0] blk, input logic [2:0] w);
    if (blk == 4'h0) return {4'h0, w};
    if (blk == 4'h1) return 7'h06 + {4'h0, w};
    return 7'h0c + {blk - 4'h2, 3'h0} + {4'h0, w};
  endfunction

  function automatic logic [3:0] lin_blk(input logic [6:0] lin);
    if (lin < 7'h06) return 4'h0;
    if (lin < 7'h0c) return 4'h1;
    return 4'((lin - 7'h0c) >> 3) + 4'h2;
  endfunction

  // bits of a block 0 parameter word that the write-protect mask freezes
  function automatic logic [31:0] b0_guard(input logic [2:0] w, input logic [31:0] wp);
    case (w)
      3'h1: return {5'h0, {3{wp[30]}}, 4'h0, {12{wp[2]}}, wp[1], {7{wp[0]}}};
      3'h2: return {{4{wp[9]}}, {4{wp[8]}}, wp[7], wp[6], wp[5], {3{wp[4]}},
                    {2{wp[3]}}, 9'h0, {3{wp[3]}}, 4'h0};
      3'h3: return {{4{wp[18]}}, 6'h0, wp[16], wp[15], 4'h0, {4{wp[13]}},
                    {4{wp[12]}}, {4{wp[11]}}, {4{wp[10]}}};
      3'h4: return {32{wp[18]}};
      default: return 32'h0;
    endcase
  endfunction
endpackage

/* File: verilog/ofc_rs_if.sv */
// word stream from the read sequencer into the block code checker
interface ofc_rs_if;
  logic        feed;
  logic        last;
  logic [31:0] word;
  logic [3:0]  tag;
  logic        done;
  logic        bad;
  logic [3:0]  done_tag;
  modport src (output feed, last, word, tag, input done, bad, done_tag);
  modport chk (input feed, last, word, tag, output done, bad, done_tag);
endinterface

/* File: verilog/ofc_rs_check.sv */
// syndrome checker for the (44,32) byte code of the coded fuse blocks
module ofc_rs_check
  import ofc_pkg::*;
#(
  parameter int NUM_SYN = 12
) (
  input  wire logic clk_sys_in,
  input  wire logic nrst_in,
  ofc_rs_if.chk     rs
);
  if (NUM_SYN < 1 || NUM_SYN > 16) begin : g_bad_syn
    $error("ofc_rs_check: NUM_SYN out of range");
  end

  logic [7:0] syn_reg  [NUM_SYN];
  logic [7:0] syn_next [NUM_SYN];

  function automatic logic [7:0] mul_alpha(input logic [7:0] x, input int n);
    logic [7:0] v;
    v = x;
    for (int k = 0; k < NUM_SYN; k++) begin
      if (k < n) v = {v[6:0], 1'b0} ^ (v[7] ? RS_POLY : 8'h00);
    end
    return v;
  endfunction

  // horner step per byte, lowest byte of the word first, roots alpha^0..
  always_comb begin
    for (int i = 0; i < NUM_SYN; i++) begin
      syn_next[i] = syn_reg[i];
      for (int b = 0; b < 4; b++) begin
        syn_next[i] = mul_alpha(syn_next[i], i) ^ rs.word[8*b +: 8];
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < NUM_SYN; i++) syn_reg[i] <= 8'h00;
      rs.done     <= 1'b0;
      rs.bad      <= 1'b0;
      rs.done_tag <= 4'h0;
    end else begin
      rs.done <= rs.feed & rs.last;
      if (rs.feed) begin
        for (int i = 0; i < NUM_SYN; i++) syn_reg[i] <= rs.last ? 8'h00 : syn_next[i];
        if (rs.last) begin
          rs.bad      <= 1'b0;
          rs.done_tag <= rs.tag;
          for (int i = 0; i < NUM_SYN; i++) begin
            if (syn_next[i] != 8'h00) rs.bad <= 1'b1;
          end
        end
      end
    end
  end
endmodule

/* File: verilog/ofc_fuse_ctrl.sv */
// one-time fuse array controller: apb registers, program and read sequencer
//
// Overview of operation
// - a set write-protect bit freezes every bit of its parameter
// - a clear write-protect bit lets unprogrammed bits of the parameter burn
// - coded blocks 1..10 are guarded by write-protect bits 20..29
// - read-protect bits 0..6 hide blocks 4..10 from software reads
// - blocks 0..3 always read back to software
// - protected key blocks still feed hardware when their purpose is nonzero
// - mask changes act only after a read refresh of the readback words
// - block 0 parameters other than the mask are kept in four copies
// - blocks 1..10 carry a (44,32) byte code, checked on read-back
// - code field arithmetic uses x^8+x^4+x^3+x^2+1
// - software supplies 12 check bytes over 32 data bytes, burnt together
// - one block per program operation, chosen by the target block select; a read refreshes blocks 0..10
// - block 0: word 0 is the mask, words 1..5 data, rest ignored
// - block 1 uses data words 0..5 and the check words
// - blocks 2..10 use all eight data words and three check words
// - hardware copies the mask and data fuse words of all blocks into readback words, but not the check words
// - done flags: bit 1 program, bit 0 read
// - six 4-bit key purpose fields, zero means software only
//
// The register offsets and the APB register port were chosen for this implementation.
module ofc_fuse_ctrl
  import ofc_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        nrst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [8:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic             fuse_req_out,
  output logic             fuse_we_out,
  output logic      [7:0]  fuse_addr_out,
  output logic      [31:0] fuse_wdata_out,
  input  wire logic        fuse_ack_in,
  input  wire logic [31:0] fuse_rdata_in,
  input  wire logic [2:0]  hw_key_sel_in,
  input  wire logic [2:0]  hw_key_word_in,
  output logic      [31:0] hw_key_data_out,
  output logic             hw_key_valid_out
);
  logic [31:0] pgm_reg [8];
  logic [31:0] chk_reg [3];
  logic [31:0] rb_reg  [RB_WORDS];
  logic [15:0] conf_reg;
  logic [3:0]  blk_sel_reg;
  logic [1:0]  cmd_reg;
  logic [1:0]  raw_reg;
  logic [1:0]  ena_reg;
  logic [10:0] err_reg;
  ofc_state_t  state_reg;
  logic [3:0]  op_blk_reg;
  logic [4:0]  slot_reg;
  logic        op_pgm_reg;
  logic [31:0] acc_reg;
  logic [31:0] first_reg;

  logic        setup;
  logic        wr;
  logic [31:0] rd_data;
  logic        hit;
  logic [6:0]  lin;
  logic [31:0] wp;
  logic [6:0]  rdp;
  logic [23:0] purp;
  logic        start_pgm;
  logic        start_rd;
  logic [1:0]  clr_set;
  logic [1:0]  done_set;
  logic [31:0] pgm_val;
  logic        is_last;
  logic        ack;
  logic [2:0]  b0w;
  logic [1:0]  b0c;

  ofc_rs_if rs ();

  ofc_rs_check #(
    .NUM_SYN (12)
  ) u_rs (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .rs         (rs)
  );

  // masks come only from the last refresh, never from the fuse cells directly
  assign wp   = rb_reg[0];
  assign rdp  = rb_reg[1][6:0];
  assign purp = {rb_reg[3][15:0], rb_reg[2][31:24]};

  assign setup = psel_in & ~penable_in;
  assign wr    = psel_in & penable_in & pready_out & pwrite_in;
  assign lin   = 7'((paddr_in - A_RB0) >> 2);

  always_comb begin
    rd_data = 32'h0;
    hit     = 1'b1;
    if (paddr_in[1:0] != 2'b00) begin
      hit = 1'b0;
    end else if (paddr_in < A_CHK0) begin
      rd_data = pgm_reg[paddr_in[4:2]];
    end else if (paddr_in < A_RB0) begin
      rd_data = chk_reg[2'((paddr_in - A_CHK0) >> 2)];
    end else if (paddr_in <= A_RB_LAST) begin
      // a hidden key block reads as zero
      if (lin_blk(lin) < FIRST_KEY || !rdp[3'(lin_blk(lin) - FIRST_KEY)]) begin
        rd_data = rb_reg[lin];
      end
    end else if (paddr_in == A_CONF) begin
      rd_data = {16'h0, conf_reg};
    end else if (paddr_in == A_CMD) begin
      rd_data = {30'h0, cmd_reg};
    end else if (paddr_in == A_RAW) begin
      rd_data = {30'h0, raw_reg};
    end else if (paddr_in == A_ENA) begin
      rd_data = {30'h0, ena_reg};
    end else if (paddr_in == A_CLR) begin
      rd_data = 32'h0;
    end else if (paddr_in == A_BLK) begin
      rd_data = {28'h0, blk_sel_reg};
    end else if (paddr_in == A_ERR) begin
      rd_data = {21'h0, err_reg};
    end else begin
      hit = 1'b0;
    end
  end

  // one wait-free access: data latched in setup, pready high in access
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prdata_out  <= 32'h0;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= setup;
      pslverr_out <= setup & ~hit;
      prdata_out  <= (setup & ~pwrite_in) ? rd_data : 32'h0;
    end
  end

  // software writable configuration and data words
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < 8; i++) pgm_reg[i] <= 32'h0;
      for (int i = 0; i < 3; i++) chk_reg[i] <= 32'h0;
      conf_reg    <= 16'h0;
      blk_sel_reg <= 4'h0;
      ena_reg     <= 2'b00;
    end else if (wr && hit) begin
      if (paddr_in < A_CHK0) begin
        pgm_reg[paddr_in[4:2]] <= pwdata_in;
      end else if (paddr_in < A_RB0) begin
        chk_reg[2'((paddr_in - A_CHK0) >> 2)] <= pwdata_in;
      end else if (paddr_in == A_CONF) begin
        conf_reg <= pwdata_in[15:0];
      end else if (paddr_in == A_BLK) begin
        blk_sel_reg <= pwdata_in[3:0];
      end else if (paddr_in == A_ENA) begin
        ena_reg <= pwdata_in[1:0];
      end
    end
  end

  // a command counts only with its own unlock key; a program also needs a legal block
  assign start_pgm = wr && paddr_in == A_CMD && state_reg == ST_IDLE
                     && pwdata_in[CMD_PGM_BIT] && conf_reg == KEY_PGM
                     && blk_sel_reg <= LAST_BLK;
  assign start_rd  = wr && paddr_in == A_CMD && state_reg == ST_IDLE
                     && pwdata_in[CMD_RD_BIT] && conf_reg == KEY_RD
                     && !start_pgm;
  assign clr_set   = (wr && paddr_in == A_CLR) ? pwdata_in[1:0] : 2'b00;
  assign done_set  = (state_reg == ST_FIN) ? (op_pgm_reg ? 2'b10 : 2'b01) : 2'b00;

  assign b0w     = b0_word(slot_reg);
  assign b0c     = 2'(slot_reg - 5'h01);
  assign is_last = slot_reg == ((op_blk_reg == 4'h0) ? B0_LAST : BLK_LAST);
  assign ack     = fuse_req_out & fuse_ack_in;

  // value to burn into the current physical word
  always_comb begin
    pgm_val = 32'h0;
    if (op_blk_reg == 4'h0) begin
      if (slot_reg == 5'h00) begin
        pgm_val = pgm_reg[0];
      end else begin
        pgm_val = pgm_reg[b0w] & ~b0_guard(b0w, wp);
      end
    end else if (wp[WP_BLK1_BIT + {1'b0, op_blk_reg} - 5'h01]) begin
      pgm_val = 32'h0;
    end else if (slot_reg >= DATA_SLOTS) begin
      pgm_val = chk_reg[2'(slot_reg - DATA_SLOTS)];
    end else if (op_blk_reg == 4'h1 && slot_reg >= B1_WORDS) begin
      pgm_val = 32'h0;
    end else begin
      pgm_val = pgm_reg[slot_reg[2:0]];
    end
  end

  assign rs.feed = state_reg == ST_RD && ack && op_blk_reg != 4'h0;
  assign rs.last = is_last;
  assign rs.word = fuse_rdata_in;
  assign rs.tag  = op_blk_reg;

  // program and read sequencer; a read refresh also runs after reset
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg      <= ST_RD;
      op_blk_reg     <= 4'h0;
      slot_reg       <= 5'h00;
      op_pgm_reg     <= 1'b0;
      cmd_reg        <= 2'b00;
      fuse_req_out   <= 1'b0;
      fuse_we_out    <= 1'b0;
      fuse_addr_out  <= 8'h00;
      fuse_wdata_out <= 32'h0;
      acc_reg        <= 32'h0;
      first_reg      <= 32'h0;
      err_reg        <= 11'h000;
      for (int i = 0; i < RB_WORDS; i++) rb_reg[i] <= 32'h0;
    end else begin
      if (rs.done) err_reg[rs.done_tag] <= rs.bad;
      case (state_reg)
        ST_IDLE: begin
          if (start_pgm || start_rd) begin
            state_reg  <= start_pgm ? ST_PGM : ST_RD;
            op_pgm_reg <= start_pgm;
            op_blk_reg <= start_pgm ? blk_sel_reg : 4'h0;
            slot_reg   <= 5'h00;
            cmd_reg    <= start_pgm ? 2'b10 : 2'b01;
            if (start_rd) err_reg <= 11'h000;
          end
        end
        ST_PGM: begin
          if (!fuse_req_out) begin
            // a zero word burns nothing and is stepped over
            if (pgm_val != 32'h0) begin
              fuse_req_out   <= 1'b1;
              fuse_we_out    <= 1'b1;
              fuse_addr_out  <= phys_addr(op_blk_reg, slot_reg);
              fuse_wdata_out <= pgm_val;
            end else if (is_last) begin
              state_reg <= ST_FIN;
            end else begin
              slot_reg <= slot_reg + 5'h01;
            end
          end else if (ack) begin
            fuse_req_out <= 1'b0;
            fuse_we_out  <= 1'b0;
            if (is_last) state_reg <= ST_FIN;
            else slot_reg <= slot_reg + 5'h01;
          end
        end
        ST_RD: begin
          if (!fuse_req_out) begin
            fuse_req_out  <= 1'b1;
            fuse_we_out   <= 1'b0;
            fuse_addr_out <= phys_addr(op_blk_reg, slot_reg);
          end else if (ack) begin
            fuse_req_out <= 1'b0;
            if (op_blk_reg == 4'h0) begin
              if (slot_reg == 5'h00) begin
                rb_reg[0] <= fuse_rdata_in;
              end else if (b0c == 2'b00) begin
                acc_reg   <= fuse_rdata_in;
                first_reg <= fuse_rdata_in;
              end else begin
                // any burnt copy counts; a mismatch is only reported
                acc_reg <= acc_reg | fuse_rdata_in;
                if (fuse_rdata_in != first_reg) err_reg[0] <= 1'b1;
                if (b0c == 2'b11) rb_reg[rb_lin(4'h0, b0w)] <= acc_reg | fuse_rdata_in;
              end
            end else if (slot_reg < DATA_SLOTS
                         && !(op_blk_reg == 4'h1 && slot_reg >= B1_WORDS)) begin
              rb_reg[rb_lin(op_blk_reg, slot_reg[2:0])] <= fuse_rdata_in;
            end
            if (!is_last) begin
              slot_reg <= slot_reg + 5'h01;
            end else if (op_blk_reg == LAST_BLK) begin
              state_reg <= ST_FIN;
            end else begin
              op_blk_reg <= op_blk_reg + 4'h1;
              slot_reg   <= 5'h00;
            end
          end
        end
        ST_FIN: begin
          cmd_reg   <= 2'b00;
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // done flags: a set in the same cycle as a clear wins
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      raw_reg <= 2'b00;
    end else begin
      // completion is polled; no interrupt line leaves this block
      raw_reg <= (raw_reg & ~clr_set) | done_set;
    end
  end

  // hardware key port ignores read protection
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hw_key_data_out  <= 32'h0;
      hw_key_valid_out <= 1'b0;
    end else if (hw_key_sel_in < KEY_COUNT && purp[{hw_key_sel_in, 2'b00} +: KP_W] != 4'h0) begin
      hw_key_valid_out <= 1'b1;
      hw_key_data_out  <= rb_reg[rb_lin(FIRST_KEY + {1'b0, hw_key_sel_in}, hw_key_word_in)];
    end else begin
      hw_key_valid_out <= 1'b0;
      hw_key_data_out  <= 32'h0;
    end
  end
endmodule

/* File: bench/ofc_fuse_chk.sv */
// port-level assertions and covers for the fuse controller
module ofc_fuse_chk (
  input wire logic        clk_sys_in,
  input wire logic        nrst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic [8:0]  paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        fuse_req_out,
  input wire logic        fuse_we_out,
  input wire logic [7:0]  fuse_addr_out,
  input wire logic [31:0] fuse_wdata_out,
  input wire logic        fuse_ack_in,
  input wire logic [31:0] hw_key_data_out,
  input wire logic        hw_key_valid_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  apb_answer_a: assert property (
    psel_in && !penable_in |=> pready_out && penable_in) else $error("setup not answered");
  ready_pulse_a: assert property (
    pready_out |=> !pready_out) else $error("ready held too long");
  idle_rdata_a: assert property (
    !pready_out |-> prdata_out == 32'h0) else $error("read data outside access");
  misalign_err_a: assert property (
    psel_in && !penable_in && paddr_in[1:0] != 2'h0 |=> pslverr_out)
    else $error("misaligned access not refused");
  fuse_hold_a: assert property (
    fuse_req_out && !fuse_ack_in |=> fuse_req_out && $stable(fuse_addr_out)
    && $stable(fuse_we_out) && $stable(fuse_wdata_out)) else $error("request changed");
  fuse_release_a: assert property (
    fuse_req_out && fuse_ack_in |=> !fuse_req_out) else $error("request not dropped");
  burn_nonzero_a: assert property (
    fuse_req_out && fuse_we_out |-> fuse_wdata_out != 32'h0) else $error("empty burn");
  fuse_range_a: assert property (
    fuse_req_out |-> fuse_addr_out <= 8'h82) else $error("fuse word out of range");
  key_gate_a: assert property (
    !hw_key_valid_out |-> hw_key_data_out == 32'h0) else $error("key leaks");
  burn_c: cover property (fuse_req_out && fuse_we_out && fuse_ack_in);
  read_c: cover property (fuse_req_out && !fuse_we_out && fuse_ack_in);
  err_c: cover property (pslverr_out);
  key_c: cover property (hw_key_valid_out);
endmodule

/* File: bench/ofc_fuse_mem.sv */
// behavioural fuse storage array answering word requests
module ofc_fuse_mem (
  input  wire logic        clk_sys_in,
  input  wire logic        nrst_in,
  input  wire logic        req_in,
  input  wire logic        we_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  output logic             ack_out,
  output logic      [31:0] rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] cells [131];
  logic [1:0]  wait_reg;
  // cells keep their value across reset, as real fuses do
  initial foreach (cells[i]) cells[i] = 32'h0;
  // answer delay follows the address so both prompt and slow answers occur
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ack_out   <= 1'b0;
      wait_reg  <= 2'h0;
      rdata_out <= 32'h0;
    end else if (ack_out) begin
      ack_out   <= 1'b0;
      rdata_out <= ~rdata_out;
    end else if (req_in && wait_reg >= addr_in[1:0]) begin
      ack_out   <= 1'b1;
      wait_reg  <= 2'h0;
      rdata_out <= we_in ? ~cells[addr_in] : cells[addr_in];
      // burning can only set bits
      if (we_in) cells[addr_in] <= cells[addr_in] | wdata_in;
    end else if (req_in) begin
      wait_reg <= wait_reg + 2'h1;
    end
  end
endmodule

/* File: bench/ofc_fuse_ctrl_tb.sv */
// self-checking bench for the fuse controller with a fuse array model
module ofc_fuse_ctrl_tb;
  import ofc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("unexpected at %0t got %h want %h", $time, a, b); end end
  typedef struct {logic [31:0] d; logic e; logic c;} ofc_exp_t;
  logic        clk_sys_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [8:0]  paddr = 9'h0;
  logic [31:0] pwdata = 32'h0, prdata, last_rd, kdata, frdata, fwdata, k0;
  logic [31:0] lf = 32'h6265;
  logic [31:0] pd [11];
  logic [31:0] b3 [11];
  logic        freq, fwe, fack, kvalid;
  logic [7:0]  faddr;
  logic [2:0]  ksel = 3'h0, kword = 3'h0;
  int          fail_count = 0, n_checks = 0;
  ofc_exp_t    expq [$];

  always #20 clk_sys_in = ~clk_sys_in;

  ofc_fuse_ctrl u_ofc_fuse_ctrl (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .fuse_req_out(freq), .fuse_we_out(fwe),
    .fuse_addr_out(faddr), .fuse_wdata_out(fwdata), .fuse_ack_in(fack),
    .fuse_rdata_in(frdata), .hw_key_sel_in(ksel), .hw_key_word_in(kword),
    .hw_key_data_out(kdata), .hw_key_valid_out(kvalid));
  ofc_fuse_mem u_ofc_fuse_mem (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .req_in(freq), .we_in(fwe),
    .addr_in(faddr), .wdata_in(fwdata), .ack_out(fack), .rdata_out(frdata));

  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // one transfer; an idle cycle follows so psel is never driven twice per step
  task automatic apb(input logic w, input logic [8:0] a, input logic [31:0] d,
                     input logic c = 1'b0, input logic e = 1'b0);
    int n;
    n = 0;
    expq.push_back('{d, e, c});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (!pready && n < 20);
    last_rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      print_verdict();
    end
    @(posedge clk_sys_in);
  endtask

  always @(posedge clk_sys_in) begin
    if (psel && penable && pready) begin
      ofc_exp_t x;
      x = expq.pop_front();
      if (x.c) begin
        `CHK(pslverr, x.e)
        if (!pwrite) `CHK(prdata, x.d)
      end
    end
  end

  task automatic poll(input logic [8:0] a, input logic [31:0] m, input logic [31:0] v);
    int k;
    for (k = 0; k < 600; k++) begin
      apb(1'b0, a, 32'h0);
      if ((last_rd & m) === v) return;
    end
    fail_count++;
    print_verdict();
  endtask

  task automatic prog(input logic [3:0] b, input logic [15:0] key);
    int i;
    apb(1'b1, A_BLK, {28'h0, b});
    for (i = 0; i < 11; i++) apb(1'b1, A_PGM0 + 9'(4 * i), pd[i]);
    apb(1'b1, A_CONF, {16'h0, key});
    apb(1'b1, A_CMD, 32'h2);
    poll(A_CMD, 32'h3, 32'h0);
    for (i = 0; i < 11; i++) apb(1'b1, A_PGM0 + 9'(4 * i), 32'h0);
  endtask

  task automatic refresh;
    apb(1'b1, A_CONF, {16'h0, KEY_RD});
    apb(1'b1, A_CMD, 32'h1);
    poll(A_CMD, 32'h3, 32'h0);
  endtask

  initial begin
    int i;
    repeat (2) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    poll(A_RAW, 32'h1, 32'h1);
    apb(1'b0, A_CMD, 32'h0, 1'b1);
    apb(1'b0, 9'h1bc, 32'h0, 1'b1, 1'b1);
    apb(1'b1, 9'h002, 32'h0, 1'b1, 1'b1);
    $display("test boot done");
    foreach (pd[i]) pd[i] = rnd();
    b3 = pd;
    prog(4'h3, 16'h0);
    `CHK(u_ofc_fuse_mem.cells[43], 32'h0)
    apb(1'b0, A_RAW, 32'h1, 1'b1);
    $display("test keyless done");
    prog(4'h3, KEY_PGM);
    apb(1'b0, A_RAW, 32'h3, 1'b1);
    apb(1'b1, A_CLR, 32'h3);
    apb(1'b0, A_RAW, 32'h0, 1'b1);
    for (i = 0; i < 11; i++) `CHK(u_ofc_fuse_mem.cells[43 + i], b3[i])
    refresh();
    for (i = 0; i < 8; i++) apb(1'b0, 9'h07c + 9'(4 * i), b3[i], 1'b1);
    apb(1'b1, 9'h07c, 32'h0);
    apb(1'b0, 9'h07c, b3[0], 1'b1);
    $display("test block3 done");
    foreach (pd[i]) pd[i] = rnd();
    prog(4'h1, KEY_PGM);
    for (i = 0; i < 11; i++) `CHK(u_ofc_fuse_mem.cells[21 + i], (i == 6 || i == 7) ? 32'h0 : pd[i])
    $display("test block1 done");
    foreach (pd[i]) pd[i] = rnd();
    k0 = pd[0];
    prog(4'h4, KEY_PGM);
    // the key block must be in the readback words before the mask is burnt
    refresh();
    foreach (pd[i]) pd[i] = rnd();
    pd[0] = 32'h0040_0000;
    pd[1] = 32'h1;
    pd[2] = 32'h0500_0000;
    for (i = 3; i < 6; i++) pd[i] = 32'h0;
    prog(4'h0, KEY_PGM);
    `CHK(u_ofc_fuse_mem.cells[0], pd[0])
    for (i = 1; i < 9; i++) `CHK(u_ofc_fuse_mem.cells[i], i < 5 ? 32'h1 : pd[2])
    for (i = 9; i < 21; i++) `CHK(u_ofc_fuse_mem.cells[i], 32'h0)
    apb(1'b0, 9'h09c, k0, 1'b1);
    refresh();
    apb(1'b0, A_RB0, pd[0], 1'b1);
    apb(1'b0, 9'h030, 32'h1, 1'b1);
    apb(1'b0, 9'h09c, 32'h0, 1'b1);
    apb(1'b0, 9'h07c, b3[0], 1'b1);
    // random words with random check bytes never form a code word; blank blocks do
    apb(1'b0, A_ERR, 32'h0000_001a, 1'b1);
    repeat (2) @(posedge clk_sys_in);
    `CHK(kvalid, 1'b1)
    `CHK(kdata, k0)
    ksel <= 3'h1;
    repeat (2) @(posedge clk_sys_in);
    `CHK(kvalid, 1'b0)
    `CHK(kdata, 32'h0)
    $display("test protect done");
    foreach (pd[i]) pd[i] = 32'hffff_ffff;
    prog(4'h3, KEY_PGM);
    for (i = 0; i < 11; i++) `CHK(u_ofc_fuse_mem.cells[43 + i], b3[i])
    refresh();
    apb(1'b0, 9'h080, b3[1], 1'b1);
    $display("test wprot done");
    print_verdict();
  end
endmodule

bind ofc_fuse_ctrl ofc_fuse_chk u_ofc_fuse_chk (.*);
